// ### verilog/spi_txbuf_defines.vh
// Register offsets, field positions, reset values for the transmit buffer block
`ifndef SPI_TXBUF_DEFINES_VH
`define SPI_TXBUF_DEFINES_VH
`define OFS_TX_HOLDING 12'h000
`define OFS_IRQ_ENABLE 12'h004
`define OFS_IRQ_FLAG 12'h008
`define OFS_IRQ_VECTOR 12'h00C
`define OFS_CONTROL 12'h010
`define OFS_IRQ_STATUS 12'h014
`define OFS_IRQ_MASK 12'h018
`define OFS_RX_HOLDING 12'h01C
`define BIT_RX 0
`define BIT_TX 1
`define BIT_CTRL_RESET 0
`define BIT_CTRL_SEVEN 1
`define RST_TX_HOLDING 8'h00
`define RST_IRQ_ENABLE 2'h0
`define RST_IRQ_FLAG 2'h2
`define RST_CONTROL 2'h1
`define VEC_NONE 16'h0000
`define VEC_RX 16'h0002
`define VEC_TX 16'h0004
`endif

// ### verilog/irq_vector_encode.v
// Priority encoder for the interrupt vector value
`timescale 1ns/1ps
`default_nettype none
module irq_vector_encode (
    input wire [1:0] flags,
    output reg [15:0] vector
);
`include "spi_txbuf_defines.vh"
    always @* begin
        if (flags[`BIT_RX]) begin
            vector = `VEC_RX;
        end else if (flags[`BIT_TX]) begin
            vector = `VEC_TX;
        end else begin
            vector = `VEC_NONE;
        end
    end
endmodule // irq_vector_encode
`default_nettype wire

// ### verilog/sticky_status.v
// Sticky event bits with write-one-to-clear; set wins over clear
`timescale 1ns/1ps
`default_nettype none
module sticky_status #(
    parameter WIDTH = 2
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] set_evt,
    input wire [WIDTH-1:0] clr_w1c,
    output wire [WIDTH-1:0] status
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // One flop per bit, so no vector has several processes driving it
            reg bit_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bit_q <= 1'b0;
                end else if (set_evt[i]) begin
                    bit_q <= 1'b1;
                end else if (clr_w1c[i]) begin
                    bit_q <= 1'b0;
                end
            end
            assign status[i] = bit_q;
        end
    endgenerate
endmodule // sticky_status
`default_nettype wire

// ### verilog/spi_tx_buffer_irq_enable.v
// Transmit holding register, interrupt enables, flags and vector behind an APB slave
//
// Contract
// - Software writes an 8-bit transmit holding value, later moved to the shifter.
// - Writing the transmit holding register clears the transmit-empty flag; while soft reset is set the code ignores the write.
// - In 7-bit mode the top bit of the holding value is dropped and reads zero.
// - Transmit interrupt enable sits at bit one, resets to zero.
// - Receive interrupt enable sits at bit zero, resets to zero.
// - Transmit-empty flag set while holding register is empty; resets set.
// - Receive-complete flag set once a whole character is received; while soft reset is set the code ignores received characters.
// - Vector reads 2 for receive (highest), 4 for transmit, else zero.
`timescale 1ns/1ps
`default_nettype none
module spi_tx_buffer_irq_enable (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire shift_load_ready,
    output wire shift_load_valid,
    output reg [7:0] shift_load_data,
    input wire rx_char_valid,
    input wire [7:0] rx_char_data,
    output wire seven_bit_mode,
    output wire soft_reset,
    output wire tx_irq_req,
    output wire rx_irq_req,
    output wire irq
);
`include "spi_txbuf_defines.vh"

    reg [7:0] tx_data_field_q;
    reg tx_full_q;
    reg [1:0] irq_enable_q;
    reg rx_complete_flag_q;
    reg [7:0] rx_data_q;
    reg [1:0] ctrl_q;
    reg [1:0] mask_q;
    wire tx_empty_flag;
    wire [1:0] flags;
    wire [15:0] irq_vector_value;
    wire [1:0] status;
    wire wr_en;
    wire rd_en;
    wire load_fire;
    wire hold_wr;
    wire [1:0] evt;
    wire [1:0] w1c;
    reg [7:0] tx_masked;
    reg mapped;

    // Zero-wait APB slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pslverr = psel & penable & ~mapped;

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `OFS_TX_HOLDING) || (a == `OFS_IRQ_ENABLE) || (a == `OFS_IRQ_FLAG) ||
                        (a == `OFS_IRQ_VECTOR) || (a == `OFS_CONTROL) || (a == `OFS_IRQ_STATUS) ||
                        (a == `OFS_IRQ_MASK) || (a == `OFS_RX_HOLDING);
        end
    endfunction

    always @* begin
        mapped = is_mapped(paddr);
    end

    assign soft_reset = ctrl_q[`BIT_CTRL_RESET];
    assign seven_bit_mode = ctrl_q[`BIT_CTRL_SEVEN];
    assign hold_wr = wr_en && (paddr == `OFS_TX_HOLDING);
    assign shift_load_valid = tx_full_q & ~soft_reset;
    assign load_fire = shift_load_valid & shift_load_ready;

    always @* begin
        tx_masked = pwdata[7:0];
        if (seven_bit_mode) begin
            tx_masked[7] = 1'b0;
        end
    end

    // Holding register and its occupancy; a load by the shifter empties it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_field_q <= `RST_TX_HOLDING;
            tx_full_q <= 1'b0;
            shift_load_data <= 8'h00;
        end else if (soft_reset) begin
            tx_full_q <= 1'b0;
            if (seven_bit_mode) begin
                tx_data_field_q[7] <= 1'b0;
            end
        end else begin
            if (hold_wr) begin
                tx_data_field_q <= tx_masked;
                tx_full_q <= 1'b1;
            end else begin
                // A byte left from 8-bit mode must not carry its top bit into 7-bit frames
                if (seven_bit_mode) begin
                    tx_data_field_q[7] <= 1'b0;
                end
                if (load_fire) begin
                    tx_full_q <= 1'b0;
                end
            end
            if (load_fire) begin
                shift_load_data <= {tx_data_field_q[7] & ~seven_bit_mode, tx_data_field_q[6:0]};
            end
        end
    end

    // Write during a load replaces the empty slot at once, so the write wins
    assign tx_empty_flag = ~tx_full_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_complete_flag_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else if (soft_reset) begin
            rx_complete_flag_q <= 1'b0;
        end else if (rx_char_valid) begin
            rx_complete_flag_q <= 1'b1;
            rx_data_q <= seven_bit_mode ? {1'b0, rx_char_data[6:0]} : rx_char_data;
        end else if (rd_en && paddr == `OFS_RX_HOLDING) begin
            rx_complete_flag_q <= 1'b0;
        end else if (wr_en && paddr == `OFS_IRQ_FLAG && !pwdata[`BIT_RX]) begin
            rx_complete_flag_q <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_q <= `RST_IRQ_ENABLE;
            ctrl_q <= `RST_CONTROL;
            mask_q <= 2'h0;
        end else if (wr_en) begin
            case (paddr)
                `OFS_IRQ_ENABLE: begin
                    irq_enable_q[`BIT_TX] <= pwdata[`BIT_TX];
                    irq_enable_q[`BIT_RX] <= pwdata[`BIT_RX];
                end
                `OFS_CONTROL: ctrl_q <= pwdata[1:0];
                `OFS_IRQ_MASK: mask_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    assign flags = {tx_empty_flag, rx_complete_flag_q};
    assign tx_irq_req = flags[`BIT_TX] & irq_enable_q[`BIT_TX];
    assign rx_irq_req = flags[`BIT_RX] & irq_enable_q[`BIT_RX];

    irq_vector_encode u_vec (
        .flags({tx_irq_req, rx_irq_req}),
        .vector(irq_vector_value)
    );

    // Sticky record of rising requests, so a brief event is not missed by software
    reg [1:0] req_prev_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prev_q <= 2'h0;
        end else begin
            req_prev_q <= {tx_irq_req, rx_irq_req};
        end
    end
    assign evt = {tx_irq_req, rx_irq_req} & ~req_prev_q;
    assign w1c = (wr_en && paddr == `OFS_IRQ_STATUS) ? pwdata[1:0] : 2'h0;

    sticky_status #(.WIDTH(2)) u_sticky (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(evt),
        .clr_w1c(w1c),
        .status(status)
    );

    assign irq = |(status & mask_q);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFS_TX_HOLDING: prdata <= {24'h000000, tx_data_field_q};
                `OFS_IRQ_ENABLE: prdata <= {30'h00000000, irq_enable_q};
                `OFS_IRQ_FLAG: prdata <= {30'h00000000, flags};
                `OFS_IRQ_VECTOR: prdata <= {16'h0000, irq_vector_value};
                `OFS_CONTROL: prdata <= {30'h00000000, ctrl_q};
                `OFS_IRQ_STATUS: prdata <= {30'h00000000, status};
                `OFS_IRQ_MASK: prdata <= {30'h00000000, mask_q};
                `OFS_RX_HOLDING: prdata <= {24'h000000, rx_data_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // spi_tx_buffer_irq_enable
`default_nettype wire

// ### testbench/spi_tx_buffer_irq_enable_assertions.sv
// Port assertions for the transmit buffer block
`timescale 1ns/1ps
`default_nettype none
`include "spi_txbuf_defines.vh"
module spi_tx_buffer_irq_enable_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic shift_load_ready,
    input wire logic shift_load_valid,
    input wire logic [7:0] shift_load_data,
    input wire logic rx_char_valid,
    input wire logic seven_bit_mode,
    input wire logic soft_reset,
    input wire logic tx_irq_req,
    input wire logic rx_irq_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wr_tx = acc && pwrite && paddr == `OFS_TX_HOLDING;
    wire take = shift_load_valid && shift_load_ready;
    ready_now_a: assert property (acc |-> pready) else $error("no ready");
    fill_on_wr_a: assert property (wr_tx && !soft_reset && !shift_load_valid |=> shift_load_valid)
        else $error("write did not fill");
    empty_after_a: assert property (take && !wr_tx |=> !shift_load_valid) else $error("stays full");
    msb_clear_a: assert property (seven_bit_mode && take |=> !shift_load_data[7]) else $error("msb set");
    tx_req_empty_a: assert property (tx_irq_req && !soft_reset |-> !shift_load_valid) else $error("req full");
    idle_in_reset_a: assert property (soft_reset |-> !shift_load_valid) else $error("load in reset");
    quiet_start_a: assert property ($rose(presetn) |-> !tx_irq_req && !rx_irq_req)
        else $error("request after reset");
    rx_req_cause_a: assert property ($rose(rx_irq_req) |-> $past(rx_char_valid) || $past(acc && pwrite))
        else $error("rx request uncaused");
    map_err_a: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h01C))
        else $error("bad slverr");
    cover property (take);
    cover property (rx_char_valid);
    cover property (seven_bit_mode && take);
endmodule // spi_tx_buffer_irq_enable_assertions
`default_nettype wire

// ### testbench/spi_far_end_model.sv
// Far-side shifter and receiver model
`timescale 1ns/1ps
`default_nettype none
module spi_far_end_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic rx_go,
    input wire logic [7:0] rx_byte,
    input wire logic shift_load_valid,
    input wire logic [7:0] shift_load_data,
    output logic shift_load_ready,
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic [7:0] got_q
);
    logic take_q;
    assign shift_load_ready = !stall;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take_q <= 1'b0;
            got_q <= 8'h00;
            rx_char_valid <= 1'b0;
            rx_char_data <= 8'h00;
        end else begin
            take_q <= shift_load_valid && shift_load_ready;
            if (take_q) got_q <= shift_load_data;
            rx_char_valid <= rx_go;
            // Toggle outside the pulse so stale data never looks valid
            rx_char_data <= rx_go ? rx_byte : ~rx_char_data;
        end
    end
endmodule // spi_far_end_model
`default_nettype wire

// ### testbench/spi_tx_buffer_irq_enable_tb.sv
// Self-checking bench for the transmit buffer block
`timescale 1ns/1ps
`default_nettype none
`include "spi_txbuf_defines.vh"
module spi_tx_buffer_irq_enable_tb;
    logic pclk, presetn, psel, penable, pwrite, stall, rx_go, pready, pslverr, err;
    logic shift_load_ready, shift_load_valid, rx_char_valid, seven_bit_mode, soft_reset, tx_irq_req, rx_irq_req, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] rx_byte, shift_load_data, rx_char_data, got_q;
    int failures, comparisons, cycles;
    spi_tx_buffer_irq_enable uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shift_load_ready(shift_load_ready), .shift_load_valid(shift_load_valid), .shift_load_data(shift_load_data),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .seven_bit_mode(seven_bit_mode),
        .soft_reset(soft_reset), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req), .irq(irq));
    spi_far_end_model far (.pclk(pclk), .presetn(presetn), .stall(stall), .rx_go(rx_go), .rx_byte(rx_byte),
        .shift_load_valid(shift_load_valid), .shift_load_data(shift_load_data), .shift_load_ready(shift_load_ready),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .got_q(got_q));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task results;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Idle edge after release, so back-to-back calls never drive psel twice in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task send(input logic [7:0] b);
        rx_byte <= b;
        rx_go <= 1'b1;
        @(posedge pclk);
        rx_go <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        stall = 1'b1;
        rx_go = 1'b0;
        rx_byte = 8'h00;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, soft_reset}, 32'h1);
        rd(`OFS_IRQ_ENABLE, 32'h0);
        rd(`OFS_IRQ_FLAG, 32'h2);
        rd(`OFS_IRQ_VECTOR, `VEC_NONE);
        wr(`OFS_CONTROL, 32'h0);
        wr(`OFS_IRQ_ENABLE, 32'h2);
        rd(`OFS_IRQ_VECTOR, `VEC_TX);
        chk({31'h0, tx_irq_req}, 32'h1);
        wr(`OFS_TX_HOLDING, 32'hA5);
        rd(`OFS_IRQ_FLAG, 32'h0);
        chk({31'h0, tx_irq_req}, 32'h0);
        rd(`OFS_TX_HOLDING, 32'hA5);
        stall <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({24'h0, got_q}, 32'hA5);
        rd(`OFS_IRQ_FLAG, 32'h2);
        wr(`OFS_IRQ_MASK, 32'h2);
        rd(`OFS_IRQ_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h2);
        rd(`OFS_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        send(8'h3C);
        rd(`OFS_IRQ_FLAG, 32'h3);
        rd(`OFS_IRQ_VECTOR, `VEC_TX);
        wr(`OFS_IRQ_ENABLE, 32'h3);
        rd(`OFS_IRQ_VECTOR, `VEC_RX);
        chk({31'h0, rx_irq_req}, 32'h1);
        rd(`OFS_RX_HOLDING, 32'h3C);
        rd(`OFS_IRQ_VECTOR, `VEC_TX);
        wr(`OFS_CONTROL, 32'h3);
        rd(`OFS_TX_HOLDING, 32'h25);
        wr(`OFS_CONTROL, 32'h2);
        chk({30'h0, soft_reset, seven_bit_mode}, 32'h1);
        stall <= 1'b1;
        wr(`OFS_TX_HOLDING, 32'hFF);
        rd(`OFS_TX_HOLDING, 32'h7F);
        stall <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({24'h0, got_q}, 32'h7F);
        send(8'hC3);
        rd(`OFS_IRQ_FLAG, 32'h3);
        wr(`OFS_IRQ_FLAG, 32'h0);
        rd(`OFS_IRQ_FLAG, 32'h2);
        rd(`OFS_RX_HOLDING, 32'h43);
        rd(12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFS_IRQ_ENABLE, 32'h0);
        rd(`OFS_IRQ_FLAG, 32'h2);
        rd(`OFS_TX_HOLDING, 32'h0);
        results();
    end
endmodule // spi_tx_buffer_irq_enable_tb
bind spi_tx_buffer_irq_enable spi_tx_buffer_irq_enable_assertions chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .shift_load_ready(shift_load_ready), .shift_load_valid(shift_load_valid), .shift_load_data(shift_load_data),
    .rx_char_valid(rx_char_valid), .seven_bit_mode(seven_bit_mode), .soft_reset(soft_reset),
    .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req));
`default_nettype wire
